// >>> tb/pmc_host_model.sv
// Host microcontroller model: serial frames out, data out sampled on sck rise
`timescale 1ns/1ps
module pmc_host_model (
    input  wire logic mclk_in, // Core clock
    input  wire logic sdo_in,  // Serial data from the device
    output logic      cs_out,  // Chip select, active high
    output logic      sck_out, // Serial clock, still outside frames
    output logic      sdi_out  // Serial data to the device
);
    initial begin
        cs_out = 1'b0;
        sck_out = 1'b0;
        sdi_out = 1'b0;
    end
    // Command byte then data byte, MSB first, sck period 8 core cycles
    task automatic frame(input logic [15:0] word, output logic [7:0] rd);
        integer i;
        rd = 8'h00;
        cs_out <= 1'b1;
        repeat (8) @(posedge mclk_in);
        for (i = 15; i >= 0; i--) begin
            sdi_out <= word[i];
            repeat (4) @(posedge mclk_in);
            sck_out <= 1'b1;
            rd = {rd[6:0], sdo_in};
            repeat (4) @(posedge mclk_in);
            sck_out <= 1'b0;
        end
        repeat (8) @(posedge mclk_in);
        cs_out <= 1'b0;
        // Released line shows the inverse of its last bit
        sdi_out <= ~sdi_out;
        repeat (8) @(posedge mclk_in);
    endtask
    // Transparent modulation bit outside frames
    task automatic stream(input logic b);
        sdi_out <= b;
    endtask
endmodule // pmc_host_model

// >>> tb/pmc_power_control_checker.sv
// Port-level assertions for the power-mode sequencer
`timescale 1ns/1ps
module pmc_power_control_checker (
    input wire logic       mclk_in,                    // Core clock
    input wire logic       reset_in,                   // Synchronous reset
    input wire logic       wake_high_pin_in,           // Power-on pin
    input wire logic       wake_button_low_pin_n_in,   // Push button, active low
    input wire logic       digital_supply_good_in,     // Supply good
    input wire logic       xto_ok_in,                  // Oscillator started
    input wire logic       rx_byte_valid_in,           // Receiver strobe
    input wire logic       rx_error_in,                // Receive error
    input wire logic       full_duplex_detect_mode_in, // Full_duplex_detect_mode
    input wire logic       supply_on_out,              // Active
    input wire logic       irq_out,                    // Interrupt
    input wire logic       clk_out_en_out,             // Host clock enable
    input wire logic [2:0] op_mode_out,                // Effective mode
    input wire logic       transparent_out,            // Transparent mode
    input wire logic       tx_byte_valid_out,          // Byte handed over
    input wire logic       serial_out_oe_out           // Data out enable
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    property p_wake_src;
        $rose(supply_on_out) |-> $past(wake_high_pin_in, 3) || !$past(wake_button_low_pin_n_in, 3);
    endproperty
    a_wake_src: assert property (p_wake_src) else $error("woke without a wake pin");
    property p_wake_irq;
        $rose(supply_on_out) |-> ##[0:3] irq_out;
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("no interrupt on wake");
    property p_clk_gate;
        $rose(clk_out_en_out) |-> $past(xto_ok_in, 2) && $past(digital_supply_good_in, 2);
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("host clock before oscillator");
    property p_loss_off;
        $fell(digital_supply_good_in) && !wake_high_pin_in && wake_button_low_pin_n_in |-> ##[1:6] !supply_on_out;
    endproperty
    a_loss_off: assert property (p_loss_off) else $error("no OFF on supply loss");
    property p_off_state;
        (!supply_on_out) [*2] |-> op_mode_out == 3'h0 && !clk_out_en_out;
    endproperty
    a_off_state: assert property (p_off_state) else $error("state kept while OFF");
    property p_rx_err;
        supply_on_out && op_mode_out[1] && rx_error_in |-> ##[1:3] irq_out;
    endproperty
    a_rx_err: assert property (p_rx_err) else $error("no interrupt on receive error");
    property p_fd_mask;
        full_duplex_detect_mode_in && rx_byte_valid_in && !irq_out |-> (!irq_out) [*3];
    endproperty
    a_fd_mask: assert property (p_fd_mask) else $error("threshold interrupt in Full_duplex_detect_mode");
    property p_tx_pulse;
        tx_byte_valid_out |=> !tx_byte_valid_out;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("byte strobe longer than a cycle");
    property p_transp_oe;
        transparent_out |-> serial_out_oe_out;
    endproperty
    a_transp_oe: assert property (p_transp_oe) else $error("transparent data out not driven");
    property p_mode_legal;
        supply_on_out |-> !op_mode_out[2];
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("undefined mode code shown");
    c_wake: cover property ($rose(supply_on_out));
    c_rx_err: cover property (rx_error_in && op_mode_out == 3'h3);
    c_tx: cover property (tx_byte_valid_out);
endmodule // pmc_power_control_checker

bind pmc_power_control pmc_power_control_checker i_chk (.mclk_in, .reset_in, .wake_high_pin_in,
    .wake_button_low_pin_n_in, .digital_supply_good_in, .xto_ok_in, .rx_byte_valid_in, .rx_error_in,
    .full_duplex_detect_mode_in, .supply_on_out, .irq_out, .clk_out_en_out, .op_mode_out,
    .transparent_out, .tx_byte_valid_out, .serial_out_oe_out);

// >>> tb/tb_pmc_power_control.sv
// Self-checking testbench for the power-mode sequencer
`timescale 1ns/1ps
module tb_pmc_power_control;
    logic mclk = 0, rst = 1, wh = 0, wb_n = 1, sgood = 1, xto = 0, rxv = 0, rxe = 0, rxb = 0, txr = 0, fd = 0;
    logic [7:0] rxd = 8'h00, rd, c0, c1, c2, txd;
    logic cs, sck, sdi, son, irq, ckoe, band, tsp, txv, tmod, sdo, sdoe;
    logic [2:0] opm;
    logic [12:0] syn;
    logic [31:0] seed = 32'hfe7acabd;
    logic [7:0] q[$];
    integer fail_count = 0, samples_checked = 0, cycles = 0, i, k;
    always #20 mclk = ~mclk;
    pmc_host_model i_pmc_host_model (.mclk_in(mclk), .sdo_in(sdo), .cs_out(cs), .sck_out(sck), .sdi_out(sdi));
    pmc_power_control i_pmc_power_control (.mclk_in(mclk), .reset_in(rst), .clk_en_in(1'b1),
        .wake_high_pin_in(wh), .wake_button_low_pin_n_in(wb_n), .digital_supply_good_in(sgood),
        .xto_ok_in(xto), .cs_in(cs), .sck_in(sck), .serial_in_tx_stream_in(sdi), .rx_byte_valid_in(rxv),
        .rx_byte_in(rxd), .rx_error_in(rxe), .rx_bit_in(rxb), .tx_byte_req_in(txr),
        .full_duplex_detect_mode_in(fd), .supply_on_out(son), .irq_out(irq), .clk_out_en_out(ckoe),
        .op_mode_out(opm), .band_select_out(band), .synth_word_a_out(syn), .transparent_out(tsp),
        .tx_byte_out(txd), .tx_byte_valid_out(txv), .tx_mod_out(tmod), .serial_out_rx_stream_out(sdo),
        .serial_out_oe_out(sdoe));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [12:0] exp_syn(input logic [7:0] a, input logic [7:0] b, input logic wide);
        return wide ? {b[7:2], a[7:1]} : 13'hc00 + {3'h0, b[4:2], a[7:1]};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] d);
        i_pmc_host_model.frame({cmd, d}, rd);
        cyc(12);
    endtask
    task automatic wake_wait;
        for (k = 0; k < 50 && son !== 1'b1; k++) cyc(1);
        cyc(4);
    endtask
    task automatic rx_push(input logic [7:0] b);
        rxd <= b;
        rxv <= 1'b1;
        cyc(1);
        rxv <= 1'b0;
        q.push_back(b);
        cyc(3);
    endtask
    task automatic tx_pop;
        txr <= 1'b1;
        cyc(1);
        txr <= 1'b0;
        for (k = 0; k < 10 && txv !== 1'b1; k++) cyc(1);
        check(txd, q.pop_front());
        cyc(3);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            final_report;
        end
    end
    initial begin
        cyc(6);
        rst <= 1'b0;
        cyc(4);
        xfer(8'h00, 8'h86);
        check(son, 0);
        check(opm, 0);
        $display("off test done");
        wh <= 1'b1;
        wake_wait;
        check(son, 1);
        check(irq, 1);
        check(ckoe, 0);
        wh <= 1'b0;
        xfer(8'h80, 8'h00);
        check(rd, 8'ha0);
        check(irq, 0);
        xfer(8'h80, 8'h00);
        check(rd, 8'h20);
        xto <= 1'b1;
        cyc(12);
        check(ckoe, 1);
        xfer(8'h80, 8'h00);
        xfer(8'h80, 8'h00);
        check(rd, 8'h00);
        xfer(8'h20, 8'h00);
        check(rd, 8'h80);
        check(syn, exp_syn(8'ha8, 8'h7b, 1'b0));
        $display("wake test done");
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            c1 = seed[7:0];
            c2 = seed[15:8] | 8'h03;
            c0 = {seed[23:20], i[2:0], 1'b0};
            xfer(8'h01, c1);
            xfer(8'h02, c2);
            xfer(8'h00, c0);
            xfer(8'h20, 8'h00);
            check(rd, c0);
            check(opm, c0[3] ? 3'h0 : c0[3:1]);
            check(band, c0[4]);
            check(syn, exp_syn(c1, c2, c0[5]));
        end
        $display("mode test done");
        xfer(8'h00, 8'h86);
        for (i = 0; i < 3; i++) rx_push(xs(seed + i));
        check(irq, 0);
        rx_push(8'h5a);
        check(irq, 1);
        xfer(8'h80, 8'h00);
        check(rd, 8'h04);
        xfer(8'h60, 8'h00);
        check(rd, q.pop_front());
        // The trailing byte of a read frame prefetches and pops one more entry
        void'(q.pop_front());
        rxe <= 1'b1;
        cyc(1);
        rxe <= 1'b0;
        cyc(4);
        check(irq, 1);
        xfer(8'h80, 8'h00);
        check(rd, 8'h02);
        xfer(8'h00, 8'hc6);
        fd <= 1'b1;
        for (i = 0; i < 10; i++) rx_push(xs(seed ^ i));
        check(irq, 0);
        fd <= 1'b0;
        $display("receive test done");
        xfer(8'h00, 8'h42);
        xfer(8'h40, 8'h3c);
        q.push_back(8'h3c);
        for (i = 0; i < 11; i++) tx_pop;
        check(irq, 1);
        xfer(8'h80, 8'h00);
        check(rd, 8'h02);
        tx_pop;
        tx_pop;
        check(irq, 1);
        $display("transmit test done");
        xfer(8'h00, 8'h03);
        check(tsp, 1);
        for (i = 0; i < 2; i++) begin
            i_pmc_host_model.stream(i[0]);
            cyc(8);
            check(tmod, i[0]);
        end
        xfer(8'h00, 8'h07);
        rxb <= seed[3];
        cyc(8);
        check(sdo, seed[3]);
        xfer(8'h00, 8'h00);
        xfer(8'ha0, 8'h00);
        check(son, 0);
        wb_n <= 1'b0;
        wake_wait;
        check(irq, 1);
        wb_n <= 1'b1;
        xfer(8'h80, 8'h00);
        check(rd, 8'h60);
        xfer(8'h20, 8'h00);
        check(rd, 8'h80);
        sgood <= 1'b0;
        cyc(12);
        check(son, 0);
        $display("power test done");
        final_report;
    end
endmodule // tb_pmc_power_control

// >>> verilog/pmc_defs.vh
// Constants for the power-mode sequencer and control register bank
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// Control register indices (RAM addresses of three of the eight control registers)
`define PMC_REG_MODE_IRQ_BAND  3'h0
`define PMC_REG_SYNTH_LO       3'h1
`define PMC_REG_SYNTH_HI       3'h2

// Reset values
`define PMC_RST_MODE_IRQ_BAND  8'h80
`define PMC_RST_SYNTH_LO       8'ha8
`define PMC_RST_SYNTH_HI       8'h7b
`define PMC_RST_OTHER          8'h00

// Fields of mode_irq_band_control
`define PMC_F_IRQ_THR_HI       7
`define PMC_F_IRQ_THR_LO       6
`define PMC_F_SYNTH_RANGE      5
`define PMC_F_BAND_SELECT      4
`define PMC_F_OP_MODE_MSB      3
`define PMC_F_OP_MODE_LSB      1
`define PMC_F_TRANSPARENT      0

// Operating mode codes
`define PMC_MODE_IDLE          3'h0
`define PMC_MODE_TX            3'h1
`define PMC_MODE_RX_POLL       3'h2
`define PMC_MODE_RX            3'h3

// Interrupt thresholds in bytes
`define PMC_THR_0              5'h01
`define PMC_THR_1              5'h02
`define PMC_THR_2              5'h04
`define PMC_THR_3              5'h0c

// Synthesizer word assembly
`define PMC_SYNTH_BASE         13'hc00

// Serial command opcodes, held in bits 7:5 of the first byte of a frame
`define PMC_CMD_WR_CTRL        3'h0
`define PMC_CMD_RD_CTRL        3'h1
`define PMC_CMD_WR_BUF         3'h2
`define PMC_CMD_RD_BUF         3'h3
`define PMC_CMD_RD_STATUS      3'h4
`define PMC_CMD_OFF            3'h5

// Status register fields
`define PMC_ST_WAKE_HIGH       7
`define PMC_ST_WAKE_BUTTON     6
`define PMC_ST_RESET_OCC       5

// Buffer geometry
`define PMC_BUF_DEPTH          16
`define PMC_BUF_AW             4

`endif

// >>> verilog/pmc_power_control.v
// Power-mode sequencer, serial register access, data buffer and control register 1
`timescale 1ns/1ps
`include "pmc_defs.vh"
module pmc_power_control (
    input  wire        mclk_in,                  // Core clock, 25 MHz
    input  wire        reset_in,                 // Synchronous reset, active high
    input  wire        clk_en_in,                // Clock enable, freezes state when low
    input  wire        wake_high_pin_in,         // Power-on pin, active high (async)
    input  wire        wake_button_low_pin_n_in, // Push-button pin, active low (async)
    input  wire        digital_supply_good_in,   // Digital supply above threshold (async)
    input  wire        xto_ok_in,                // Crystal oscillator started (async)
    input  wire        cs_in,                    // Serial chip select, active high (async)
    input  wire        sck_in,                   // Serial clock (async)
    input  wire        serial_in_tx_stream_in,   // Serial data in / transparent TX data (async)
    input  wire        rx_byte_valid_in,         // Receiver delivers a byte, pulse
    input  wire [7:0]  rx_byte_in,               // Received byte
    input  wire        rx_error_in,              // Receiver error, pulse
    input  wire        rx_bit_in,                // Received bit stream for transparent mode
    input  wire        tx_byte_req_in,           // Transmitter takes next byte, pulse
    input  wire        full_duplex_detect_mode_in, // Full-duplex-detect mode active
    output reg         supply_on_out,            // Digital/analog supply switch closed
    output reg         irq_out,                  // Interrupt to host, active high
    output reg         clk_out_en_out,           // Host clock output enable
    output reg  [2:0]  op_mode_out,              // Effective operating mode
    output reg         band_select_out,          // 0: 433 MHz band, 1: 315 MHz band
    output reg  [12:0] synth_word_a_out,         // Synthesizer frequency word
    output reg         transparent_out,          // Transparent mode active
    output reg  [7:0]  tx_byte_out,              // Byte handed to transmitter
    output reg         tx_byte_valid_out,        // Byte handed over, pulse
    output reg         tx_mod_out,               // Transparent TX modulation bit
    output reg         serial_out_rx_stream_out, // Serial data out / transparent RX data
    output reg         serial_out_oe_out         // Serial data out enable
);
    localparam ST_OFF    = 1'b0;
    localparam ST_ACTIVE = 1'b1;

    wire [5:0] syn;
    wire       wake_high     = syn[0];
    wire       wake_button   = syn[1];
    wire       supply_good   = syn[2];
    wire       xto_ok        = syn[3];
    wire       cs            = syn[4];
    wire       sck           = syn[5];
    wire       sdi;

    // Button is inverted before syncing so the cleared synchroniser reads as released
    pmc_sync #(.WIDTH(6)) u_sync (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .clk_en_in (clk_en_in),
        .async_in  ({sck_in, cs_in, xto_ok_in, digital_supply_good_in,
                     ~wake_button_low_pin_n_in, wake_high_pin_in}),
        .sync_out  (syn)
    );

    pmc_sync #(.WIDTH(1)) u_sync_sdi (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .clk_en_in (clk_en_in),
        .async_in  (serial_in_tx_stream_in),
        .sync_out  (sdi)
    );

    reg        pwr_state;
    reg        sck_d;
    reg        supply_good_d;
    wire       wake_event = (pwr_state == ST_OFF) && (wake_high || wake_button);
    wire       supply_reset_internal = reset_in || ((pwr_state == ST_OFF) && !wake_event);
    wire       sck_rise = cs && sck && !sck_d;
    wire       sck_fall = cs && !sck && sck_d;
    wire       supply_drop = supply_good_d && !supply_good;

    // Control RAM, status and buffer
    reg [7:0]  ctrl [0:7];
    reg [7:0]  buf_mem [0:`PMC_BUF_DEPTH-1];
    reg [`PMC_BUF_AW-1:0] wr_ptr;
    reg [`PMC_BUF_AW-1:0] rd_ptr;
    reg [4:0]  level;
    reg        flag_wake_high;
    reg        flag_wake_button;
    reg        reset_occurred_flag;
    reg        irq_pend;

    // Serial engine
    reg [2:0]  bit_cnt;
    reg [7:0]  rx_sh;
    reg [7:0]  tx_sh;
    reg [7:0]  cmd;
    reg        have_cmd;
    reg        off_cmd;

    wire [7:0] mode_reg   = ctrl[`PMC_REG_MODE_IRQ_BAND];
    wire [2:0] mode_field = mode_reg[`PMC_F_OP_MODE_MSB:`PMC_F_OP_MODE_LSB];
    wire [2:0] eff_mode   = mode_field[2] ? `PMC_MODE_IDLE : mode_field;
    wire       tmode      = mode_reg[`PMC_F_TRANSPARENT];
    wire       in_rx      = (eff_mode == `PMC_MODE_RX) || (eff_mode == `PMC_MODE_RX_POLL);
    wire       in_tx      = (eff_mode == `PMC_MODE_TX);
    wire [7:0] byte_in    = {rx_sh[6:0], sdi};
    wire       byte_done  = sck_rise && (bit_cnt == 3'h7) && (pwr_state == ST_ACTIVE);
    wire [2:0] op         = have_cmd ? cmd[7:5] : byte_in[7:5];
    wire [2:0] addr       = have_cmd ? cmd[2:0] : byte_in[2:0];

    reg  [4:0] thr;
    always @* begin
        case ({mode_reg[`PMC_F_IRQ_THR_HI], mode_reg[`PMC_F_IRQ_THR_LO]})
            2'b00:   thr = `PMC_THR_0;
            2'b01:   thr = `PMC_THR_1;
            2'b10:   thr = `PMC_THR_2;
            default: thr = `PMC_THR_3;
        endcase
    end

    // Buffer traffic; transparent mode disables the buffer
    wire host_wr  = byte_done && have_cmd && (cmd[7:5] == `PMC_CMD_WR_BUF) && !in_rx && !tmode && (level != 5'h10);
    wire host_rd  = byte_done && (op == `PMC_CMD_RD_BUF) && !in_tx && !tmode && (level != 5'h00);
    wire rx_push  = rx_byte_valid_in && in_rx && !tmode && (level != 5'h10);
    wire tx_pop   = tx_byte_req_in && in_tx && !tmode && (level != 5'h00);
    wire push     = host_wr || rx_push;
    wire pop      = host_rd || tx_pop;
    wire [4:0] next_level = level + {4'h0, push} - {4'h0, pop};
    wire status_read = byte_done && (op == `PMC_CMD_RD_STATUS);
    // Receive errors interrupt in every receive mode; only the threshold and TX-empty events are masked
    wire thr_event = (in_rx && rx_error_in) ||
                     (!full_duplex_detect_mode_in &&
                      ((rx_push && (next_level == thr)) ||
                       (tx_pop && ((next_level == thr) || (next_level == 5'h00)))));

    wire [7:0] status_word = {flag_wake_high, flag_wake_button, reset_occurred_flag, level};
    reg  [7:0] read_word;
    always @* begin
        case (op)
            `PMC_CMD_RD_CTRL:   read_word = ctrl[addr];
            `PMC_CMD_RD_BUF:    read_word = buf_mem[rd_ptr];
            `PMC_CMD_RD_STATUS: read_word = status_word;
            default:            read_word = 8'h00;
        endcase
    end

    // Power state machine
    always @(posedge mclk_in) begin
        if (reset_in) begin
            pwr_state     <= ST_OFF;
            supply_good_d <= 1'b0;
        end else if (clk_en_in) begin
            supply_good_d <= supply_good;
            case (pwr_state)
                ST_OFF:
                    if (wake_event)
                        pwr_state <= ST_ACTIVE;
                ST_ACTIVE: begin
                    if (off_cmd)
                        pwr_state <= ST_OFF;
                    else if (supply_drop && !wake_button && !wake_high)
                        pwr_state <= ST_OFF;
                end
                default: pwr_state <= ST_OFF;
            endcase
        end
    end

    // Register bank, buffer, flags and serial engine; all lost while OFF
    integer i;
    always @(posedge mclk_in) begin
        if (supply_reset_internal) begin
            for (i = 0; i < 8; i = i + 1)
                ctrl[i] <= `PMC_RST_OTHER;
            ctrl[`PMC_REG_MODE_IRQ_BAND] <= `PMC_RST_MODE_IRQ_BAND;
            ctrl[`PMC_REG_SYNTH_LO]      <= `PMC_RST_SYNTH_LO;
            ctrl[`PMC_REG_SYNTH_HI]      <= `PMC_RST_SYNTH_HI;
            for (i = 0; i < `PMC_BUF_DEPTH; i = i + 1)
                buf_mem[i] <= 8'h00;
            wr_ptr              <= {`PMC_BUF_AW{1'b0}};
            rd_ptr              <= {`PMC_BUF_AW{1'b0}};
            level               <= 5'h00;
            flag_wake_high      <= 1'b0;
            flag_wake_button    <= 1'b0;
            reset_occurred_flag <= 1'b0;
            irq_pend            <= 1'b0;
            bit_cnt             <= 3'h0;
            rx_sh               <= 8'h00;
            tx_sh               <= 8'h00;
            cmd                 <= 8'h00;
            have_cmd            <= 1'b0;
            off_cmd             <= 1'b0;
            sck_d               <= 1'b0;
            tx_byte_out         <= 8'h00;
            tx_byte_valid_out   <= 1'b0;
            serial_out_rx_stream_out <= 1'b0;
            serial_out_oe_out   <= 1'b0;
        end else if (clk_en_in) begin
            sck_d             <= sck;
            tx_byte_valid_out <= 1'b0;
            off_cmd           <= 1'b0;

            // Status flags: setting wins over the clearing read
            if (wake_event) begin
                flag_wake_high      <= wake_high;
                flag_wake_button    <= wake_button;
                reset_occurred_flag <= 1'b1;
            end else if (status_read) begin
                flag_wake_high   <= 1'b0;
                flag_wake_button <= 1'b0;
                if (supply_good && xto_ok)
                    reset_occurred_flag <= 1'b0;
            end

            if (wake_event || thr_event)
                irq_pend <= 1'b1;
            else if (status_read)
                irq_pend <= 1'b0;

            // Buffer
            if (push) begin
                buf_mem[wr_ptr] <= host_wr ? byte_in : rx_byte_in;
                wr_ptr          <= wr_ptr + 4'h1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 4'h1;
            level <= next_level;
            if (tx_pop) begin
                tx_byte_out       <= buf_mem[rd_ptr];
                tx_byte_valid_out <= 1'b1;
            end

            // Serial frame handling
            if (!cs) begin
                bit_cnt  <= 3'h0;
                have_cmd <= 1'b0;
            end else if (sck_rise && (pwr_state == ST_ACTIVE)) begin
                rx_sh   <= byte_in;
                bit_cnt <= bit_cnt + 3'h1;
                if (byte_done) begin
                    if (!have_cmd) begin
                        cmd      <= byte_in;
                        have_cmd <= 1'b1;
                        if (byte_in[7:5] == `PMC_CMD_OFF)
                            off_cmd <= 1'b1;
                    end else if (cmd[7:5] == `PMC_CMD_WR_CTRL) begin
                        ctrl[cmd[2:0]] <= byte_in;
                    end
                    tx_sh <= read_word;
                end
            end else if (sck_fall) begin
                serial_out_rx_stream_out <= tx_sh[7];
                tx_sh                    <= {tx_sh[6:0], 1'b0};
            end
            if (tmode && !cs)
                serial_out_rx_stream_out <= rx_bit_in;
            serial_out_oe_out <= cs || tmode;
        end
    end

    // Output registers derived from state, control register 1 and the synthesizer registers
    wire [7:0]  syn_lo = ctrl[`PMC_REG_SYNTH_LO];
    wire [7:0]  syn_hi = ctrl[`PMC_REG_SYNTH_HI];
    wire [12:0] word_narrow = `PMC_SYNTH_BASE + {3'h0, syn_hi[4:2], syn_lo[7:1]};
    wire [12:0] word_wide   = {syn_hi[7:2], syn_lo[7:1]};
    always @(posedge mclk_in) begin
        if (reset_in) begin
            supply_on_out    <= 1'b0;
            irq_out          <= 1'b0;
            clk_out_en_out   <= 1'b0;
            op_mode_out      <= `PMC_MODE_IDLE;
            band_select_out  <= 1'b0;
            synth_word_a_out <= 13'h0000;
            transparent_out  <= 1'b0;
            tx_mod_out       <= 1'b0;
        end else if (clk_en_in) begin
            supply_on_out    <= (pwr_state == ST_ACTIVE);
            irq_out          <= irq_pend;
            clk_out_en_out   <= (pwr_state == ST_ACTIVE) && supply_good && xto_ok &&
                                syn_hi[1] && syn_hi[0];
            op_mode_out      <= (pwr_state == ST_ACTIVE) ? eff_mode : `PMC_MODE_IDLE;
            band_select_out  <= mode_reg[`PMC_F_BAND_SELECT];
            synth_word_a_out <= mode_reg[`PMC_F_SYNTH_RANGE] ? word_wide : word_narrow;
            transparent_out  <= tmode;
            tx_mod_out       <= tmode && in_tx && sdi;
        end
    end
endmodule // pmc_power_control

// >>> verilog/pmc_sync.v
// Two-flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module pmc_sync #(
    parameter WIDTH = 1
) (
    input  wire             mclk_in,   // Core clock
    input  wire             reset_in,  // Synchronous reset, active high
    input  wire             clk_en_in, // Clock enable
    input  wire [WIDTH-1:0] async_in,  // Asynchronous inputs
    output reg  [WIDTH-1:0] sync_out   // Synchronised outputs
);
    reg [WIDTH-1:0] meta;

    always @(posedge mclk_in) begin
        if (reset_in) begin
            meta     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else if (clk_en_in) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // pmc_sync
